// file: pkg/cfd_pkg.sv
package cfd_pkg;

    // Operation classes handed over by the sequencer with each word
    typedef enum logic [1:0] {
        CFD_OP_NONE = 2'b00,
        CFD_OP_MF64 = 2'b01,
        CFD_OP_MRMOVE = 2'b11,
        CFD_OP_FXADD = 2'b10
    } cfd_op_t;

    // Word and register geometry
    localparam int CFD_INSTR_W = 32;
    localparam int CFD_REG_W = 40;
    localparam int CFD_FIX_W = 32;
    localparam int CFD_EXT_W = 8;
    localparam int CFD_NUM_REGS = 16;
    localparam int CFD_NUM_SLICES = 6;

    // Multi-function 64-bit float field positions (low bit of each, plus the multiplier result's high bit)
    localparam int CFD_MF_MUL_RES_LSB = 12;
    localparam int CFD_MF_MUL_RES_MSB = 15;
    localparam int CFD_MF_ADD_RES_LSB = 8;
    localparam int CFD_MF_MUL_S1_LSB = 6;
    localparam int CFD_MF_MUL_S2_LSB = 4;
    localparam int CFD_MF_ADD_S1_LSB = 2;
    localparam int CFD_MF_ADD_S2_LSB = 0;

    // Source selector codes and the pair base registers they pick
    localparam logic [1:0] CFD_SRC_LOW = 2'h0;
    localparam logic [1:0] CFD_SRC_HIGH = 2'h2;
    localparam logic [3:0] CFD_MUL_S1_BASE = 4'h0;
    localparam logic [3:0] CFD_MUL_S2_BASE = 4'h4;
    localparam logic [3:0] CFD_ADD_S1_BASE = 4'h8;
    localparam logic [3:0] CFD_ADD_S2_BASE = 4'hC;
    localparam logic [3:0] CFD_PAIR_STEP = 4'h2;

    // Fixed-point single-register fields
    localparam int CFD_DST_LSB = 8;
    localparam int CFD_RX_LSB = 4;
    localparam int CFD_RY_LSB = 0;

    // Multiplier result move fields and slice codes
    localparam int CFD_MV_DIR_BIT = 16;
    localparam int CFD_MV_SLICE_LSB = 12;
    localparam logic [3:0] CFD_SL_FG0 = 4'h0;
    localparam logic [3:0] CFD_SL_FG1 = 4'h1;
    localparam logic [3:0] CFD_SL_FG2 = 4'h2;
    localparam logic [3:0] CFD_SL_BG0 = 4'h4;
    localparam logic [3:0] CFD_SL_BG1 = 4'h5;
    localparam logic [3:0] CFD_SL_BG2 = 4'h6;

    // Saturation limits
    localparam logic [31:0] CFD_SAT_POS = 32'h7FFFFFFF;
    localparam logic [31:0] CFD_SAT_NEG = 32'h80000000;

    // Values after reset
    localparam logic [39:0] CFD_REG_RST = 40'h0000000000;
    localparam logic [7:0] CFD_CMP_HIST_RST = 8'h00;
    localparam logic CFD_FLAG_RST = 1'b0;

endpackage

// file: design/cfd_fix_adder.sv
`timescale 1ns/1ps
`default_nettype none

// Fixed-point adder with saturation and the arithmetic status it produces
module cfd_fix_adder
#(
    parameter int WIDTH = 32
)
(
    input wire logic [WIDTH-1:0] opa_i,
    input wire logic [WIDTH-1:0] opb_i,
    input wire logic sat_en_i,
    output logic [WIDTH-1:0] sum_o,
    output logic carry_o,
    output logic neg_o,
    output logic ovf_o,
    output logic zero_o
);
    import cfd_pkg::*;

    logic [WIDTH-1:0] low_sum;
    logic [WIDTH:0] full_sum;
    logic carry_into_msb;
    logic pos_ovf;
    logic neg_ovf;

    // Low stages kept apart so the carry into the top stage is visible
    assign low_sum = {1'b0, opa_i[WIDTH-2:0]} + {1'b0, opb_i[WIDTH-2:0]};
    assign carry_into_msb = low_sum[WIDTH-1];
    assign full_sum = {1'b0, opa_i} + {1'b0, opb_i};

    // Overflow direction follows the sign of the operands
    assign pos_ovf = ovf_o & ~opa_i[WIDTH-1];
    assign neg_ovf = ovf_o & opa_i[WIDTH-1];

    // Result and flags
    assign carry_o = full_sum[WIDTH]; // RULE16
    assign ovf_o = carry_into_msb ^ full_sum[WIDTH]; // RULE18
    assign sum_o = (sat_en_i && pos_ovf) ? CFD_SAT_POS[WIDTH-1:0] : // RULE15
                   (sat_en_i && neg_ovf) ? CFD_SAT_NEG[WIDTH-1:0] : // RULE15
                   full_sum[WIDTH-1:0]; // RULE14
    assign neg_o = sum_o[WIDTH-1]; // RULE17
    assign zero_o = (sum_o == '0); // RULE19

endmodule

`default_nettype wire

// file: design/cfd_compute_decode.sv
// How it works
// RULE1: bits 15:12 pick multiplier result pair
// RULE2: bits 11:8 pick add/subtract result pair
// RULE3: multiplier source one: 00 pair 1:0, 10 pair 3:2
// RULE4: multiplier source two: 00 pair 5:4, 10 pair 7:6
// RULE5: add source one: 00 pair 9:8, 10 pair 11:10
// RULE6: add source two: 00 pair 13:12, 10 pair 15:14
// RULE7: source codes 01 and 11 flag illegal word
// RULE8: single register code equals register number
// RULE9: pair codes must be even; odd selects nothing
// RULE10: bit 16 sets move direction
// RULE11: bits 15:12 select foreground/background result slice
// RULE12: fixed-point operation clears float operation flag
// RULE13: add leaves compare history unchanged
// RULE14: add writes sum, zeroes extension bits
// RULE15: saturation clamps to 0x7FFFFFFF or 0x80000000
// RULE16: carry flag is carry out of top stage
// RULE17: negative flag is result most significant bit
// RULE18: overflow flag is xor of top carries
// RULE19: zero flag set when result all zero
// RULE20: add clears invalid and sign flags
// RULE21: overflow sets sticky; other stickies unchanged
`timescale 1ns/1ps
`default_nettype none

module cfd_compute_decode
#(
    parameter int NUM_REGS = 16,
    parameter int REG_W = 40,
    parameter int FIX_W = 32
)
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Instruction from the sequencer, one per cycle
    input wire logic instr_valid_i,
    input wire cfd_pkg::cfd_op_t instr_op_i,
    input wire logic [cfd_pkg::CFD_INSTR_W-1:0] instr_word_i,
    // Mode and sticky control
    input wire logic alu_saturate_enable_i,
    input wire logic sticky_clr_i,
    // Loading and inspecting the data register file
    input wire logic rf_wr_en_i,
    input wire logic [3:0] rf_wr_idx_i,
    input wire logic [REG_W-1:0] rf_wr_data_i,
    input wire logic [3:0] rf_rd_idx_i,
    output logic [REG_W-1:0] rf_rd_data_o,
    input wire logic [2:0] slice_rd_idx_i,
    output logic [FIX_W-1:0] slice_rd_data_o,
    // Decoded multi-function 64-bit float selectors (pair base register)
    output logic dec_valid_o,
    output logic illegal_o,
    output logic [3:0] mul_result_pair_sel_o,
    output logic [3:0] addsub_result_pair_sel_o,
    output logic [3:0] mul_src1_pair_sel_o,
    output logic [3:0] mul_src2_pair_sel_o,
    output logic [3:0] addsub_src1_pair_sel_o,
    output logic [3:0] addsub_src2_pair_sel_o,
    // Decoded move
    output logic mul_result_transfer_op_o,
    output logic mul_result_move_dir_o,
    output logic [3:0] dest_data_reg_o,
    // Arithmetic status of this processing element
    output logic float_op_flag_o,
    output logic alu_carry_flag_o,
    output logic alu_negative_flag_o,
    output logic alu_overflow_flag_o,
    output logic alu_zero_flag_o,
    output logic alu_invalid_flag_o,
    output logic alu_sign_flag_o,
    output logic [7:0] compare_history_bits_o,
    // Sticky status of this processing element
    output logic alu_overflow_sticky_o,
    output logic alu_underflow_sticky_o,
    output logic alu_invalid_sticky_o,
    output logic alu_float_overflow_sticky_o
);
    import cfd_pkg::*;

    // Data register file and the six multiplier result slices
    logic [REG_W-1:0] rf_r [NUM_REGS];
    logic [FIX_W-1:0] slice_r [CFD_NUM_SLICES];

    // Pair code check: valid only when even, base is the code itself
    function automatic logic pair_ok(input logic [3:0] code);
        pair_ok = ~code[0]; // RULE9
    endfunction

    // Source selector to pair base; only 00 and 10 are defined
    function automatic logic [3:0] src_pair(input logic [1:0] code,
                                            input logic [3:0] base);
        src_pair = (code == CFD_SRC_HIGH) ? base + CFD_PAIR_STEP : base;
    endfunction

    function automatic logic src_ok(input logic [1:0] code);
        src_ok = (code == CFD_SRC_LOW) || (code == CFD_SRC_HIGH); // RULE7
    endfunction

    // Slice code to slice index; undefined codes report not valid
    function automatic logic [3:0] slice_idx(input logic [3:0] code);
        if (code == CFD_SL_FG0)
            slice_idx = 4'h0;
        else if (code == CFD_SL_FG1)
            slice_idx = 4'h1;
        else if (code == CFD_SL_FG2)
            slice_idx = 4'h2;
        else if (code == CFD_SL_BG0)
            slice_idx = 4'h3;
        else if (code == CFD_SL_BG1)
            slice_idx = 4'h4;
        else if (code == CFD_SL_BG2)
            slice_idx = 4'h5;
        else
            slice_idx = 4'hF;
    endfunction

    // Multi-function field extraction
    wire [3:0] mul_res_code = instr_word_i[CFD_MF_MUL_RES_MSB:
                                           CFD_MF_MUL_RES_LSB]; // RULE1
    wire [3:0] add_res_code = instr_word_i[CFD_MF_ADD_RES_LSB+3:
                                           CFD_MF_ADD_RES_LSB]; // RULE2
    wire [1:0] mul_s1_code = instr_word_i[CFD_MF_MUL_S1_LSB+1:
                                          CFD_MF_MUL_S1_LSB];
    wire [1:0] mul_s2_code = instr_word_i[CFD_MF_MUL_S2_LSB+1:
                                          CFD_MF_MUL_S2_LSB];
    wire [1:0] add_s1_code = instr_word_i[CFD_MF_ADD_S1_LSB+1:
                                          CFD_MF_ADD_S1_LSB];
    wire [1:0] add_s2_code = instr_word_i[CFD_MF_ADD_S2_LSB+1:
                                          CFD_MF_ADD_S2_LSB];

    // A legal multi-function word needs even result pairs and defined sources
    wire mf_legal = pair_ok(mul_res_code) && pair_ok(add_res_code) &&
                    src_ok(mul_s1_code) && src_ok(mul_s2_code) &&
                    src_ok(add_s1_code) && src_ok(add_s2_code); // RULE7

    wire [3:0] mul_s1_pair = src_pair(mul_s1_code, CFD_MUL_S1_BASE); // RULE3
    wire [3:0] mul_s2_pair = src_pair(mul_s2_code, CFD_MUL_S2_BASE); // RULE4
    wire [3:0] add_s1_pair = src_pair(add_s1_code, CFD_ADD_S1_BASE); // RULE5
    wire [3:0] add_s2_pair = src_pair(add_s2_code, CFD_ADD_S2_BASE); // RULE6

    // Single-register fields: the code is the register number
    wire [3:0] dst_idx = instr_word_i[CFD_DST_LSB+3:CFD_DST_LSB]; // RULE8
    wire [3:0] rx_idx = instr_word_i[CFD_RX_LSB+3:CFD_RX_LSB]; // RULE8
    wire [3:0] ry_idx = instr_word_i[CFD_RY_LSB+3:CFD_RY_LSB]; // RULE8

    // Move fields
    wire mv_dir = instr_word_i[CFD_MV_DIR_BIT]; // RULE10
    wire [3:0] mv_code = instr_word_i[CFD_MV_SLICE_LSB+3:CFD_MV_SLICE_LSB];
    wire [3:0] mv_slice = slice_idx(mv_code); // RULE11
    wire mv_legal = (mv_slice != 4'hF);

    // Operation qualifiers
    wire do_mf = instr_valid_i && (instr_op_i == CFD_OP_MF64);
    wire do_mv = instr_valid_i && (instr_op_i == CFD_OP_MRMOVE);
    wire do_add = instr_valid_i && (instr_op_i == CFD_OP_FXADD);
    wire do_mv_ok = do_mv && mv_legal;
    wire word_illegal = (do_mf && !mf_legal) || (do_mv && !mv_legal);

    // Fixed-point fields sit above the floating-point extension bits
    wire [FIX_W-1:0] add_opa = rf_r[rx_idx][REG_W-1:REG_W-FIX_W];
    wire [FIX_W-1:0] add_opb = rf_r[ry_idx][REG_W-1:REG_W-FIX_W];
    logic [FIX_W-1:0] add_sum;
    logic add_carry;
    logic add_neg;
    logic add_ovf;
    logic add_zero;

    cfd_fix_adder #(
        .WIDTH(FIX_W)
    ) u_adder (
        .opa_i(add_opa),
        .opb_i(add_opb),
        .sat_en_i(alu_saturate_enable_i),
        .sum_o(add_sum),
        .carry_o(add_carry),
        .neg_o(add_neg),
        .ovf_o(add_ovf),
        .zero_o(add_zero)
    );

    // Register file write: instruction results win over the load port,
    // since a load racing a result would otherwise hide the result
    wire [CFD_EXT_W-1:0] ext_zero = '0;
    wire ins_wr = do_add || (do_mv_ok && !mv_dir);
    wire [3:0] ins_wr_idx = dst_idx;
    wire [REG_W-1:0] ins_wr_data = do_add ?
        {add_sum, ext_zero} : // RULE14
        {slice_r[mv_slice[2:0]], ext_zero}; // RULE10

    always_ff @(posedge sys_clk_i)
    begin
        for (int i = 0; i < NUM_REGS; i++)
        begin
            if (srst_i)
                rf_r[i] <= CFD_REG_RST[REG_W-1:0];
            else if (ins_wr && (ins_wr_idx == 4'(i)))
                rf_r[i] <= ins_wr_data;
            else if (rf_wr_en_i && (rf_wr_idx_i == 4'(i)))
                rf_r[i] <= rf_wr_data_i;
        end
    end

    // Slice write from the register file's fixed-point field
    always_ff @(posedge sys_clk_i)
    begin
        for (int i = 0; i < CFD_NUM_SLICES; i++)
        begin
            if (srst_i)
                slice_r[i] <= '0;
            else if (do_mv_ok && mv_dir && (mv_slice == 4'(i))) // RULE10
                slice_r[i] <= rf_r[dst_idx][REG_W-1:REG_W-FIX_W]; // RULE11
        end
    end

    // Read-back ports, registered; out-of-range slice reads return zero
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            rf_rd_data_o <= '0;
            slice_rd_data_o <= '0;
        end
        else
        begin
            rf_rd_data_o <= rf_r[rf_rd_idx_i];
            slice_rd_data_o <= (slice_rd_idx_i < 3'(CFD_NUM_SLICES)) ?
                               slice_r[slice_rd_idx_i] : '0;
        end
    end

    // Decode outputs, one cycle after the word; selectors hold until next
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            dec_valid_o <= 1'b0;
            illegal_o <= 1'b0;
            mul_result_pair_sel_o <= '0;
            addsub_result_pair_sel_o <= '0;
            mul_src1_pair_sel_o <= '0;
            mul_src2_pair_sel_o <= '0;
            addsub_src1_pair_sel_o <= '0;
            addsub_src2_pair_sel_o <= '0;
            mul_result_transfer_op_o <= 1'b0;
            mul_result_move_dir_o <= 1'b0;
            dest_data_reg_o <= '0;
        end
        else
        begin
            dec_valid_o <= do_mf && mf_legal; // RULE7
            illegal_o <= word_illegal; // RULE7
            mul_result_transfer_op_o <= do_mv_ok;
            if (do_mf && mf_legal)
            begin
                mul_result_pair_sel_o <= mul_res_code; // RULE1
                addsub_result_pair_sel_o <= add_res_code; // RULE2
                mul_src1_pair_sel_o <= mul_s1_pair;
                mul_src2_pair_sel_o <= mul_s2_pair;
                addsub_src1_pair_sel_o <= add_s1_pair;
                addsub_src2_pair_sel_o <= add_s2_pair;
            end
            if (do_mv_ok)
            begin
                mul_result_move_dir_o <= mv_dir; // RULE10
                dest_data_reg_o <= dst_idx; // RULE8
            end
        end
    end

    // Arithmetic status: only the add changes it here; compare history
    // has no writer in this block and so only resets
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            float_op_flag_o <= CFD_FLAG_RST;
            alu_carry_flag_o <= CFD_FLAG_RST;
            alu_negative_flag_o <= CFD_FLAG_RST;
            alu_overflow_flag_o <= CFD_FLAG_RST;
            alu_zero_flag_o <= CFD_FLAG_RST;
            alu_invalid_flag_o <= CFD_FLAG_RST;
            alu_sign_flag_o <= CFD_FLAG_RST;
            compare_history_bits_o <= CFD_CMP_HIST_RST;
        end
        else if (do_add)
        begin
            float_op_flag_o <= 1'b0; // RULE12
            alu_carry_flag_o <= add_carry; // RULE16
            alu_negative_flag_o <= add_neg; // RULE17
            alu_overflow_flag_o <= add_ovf; // RULE18
            alu_zero_flag_o <= add_zero; // RULE19
            alu_invalid_flag_o <= 1'b0; // RULE20
            alu_sign_flag_o <= 1'b0; // RULE20
            compare_history_bits_o <= compare_history_bits_o; // RULE13
        end
    end

    // Sticky status: a set in the same cycle as a clear wins
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            alu_overflow_sticky_o <= CFD_FLAG_RST;
            alu_underflow_sticky_o <= CFD_FLAG_RST;
            alu_invalid_sticky_o <= CFD_FLAG_RST;
            alu_float_overflow_sticky_o <= CFD_FLAG_RST;
        end
        else
        begin
            if (do_add && add_ovf)
                alu_overflow_sticky_o <= 1'b1; // RULE21
            else if (sticky_clr_i)
                alu_overflow_sticky_o <= 1'b0;
            if (sticky_clr_i)
            begin
                alu_underflow_sticky_o <= 1'b0;
                alu_invalid_sticky_o <= 1'b0;
                alu_float_overflow_sticky_o <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// file: verif/cfd_seq_model.sv
`timescale 1ns/1ps
`default_nettype none

// Sequencer stand-in: hands one compute word to the decoder per call
module cfd_seq_model
(
    input wire logic sys_clk_i,
    output logic instr_valid_o,
    output cfd_pkg::cfd_op_t instr_op_o,
    output logic [31:0] instr_word_o
);
    import cfd_pkg::*;

    // Idle at time zero
    initial
    begin
        instr_valid_o = 1'b0;
        instr_op_o = CFD_OP_NONE;
        instr_word_o = 32'h00000000;
    end

    // Idle word is inverted so a stale word can never look right
    task automatic issue(input cfd_op_t op, input logic [31:0] word);
        @(posedge sys_clk_i);
        instr_valid_o <= 1'b1;
        instr_op_o <= op;
        instr_word_o <= word;
        @(posedge sys_clk_i);
        instr_valid_o <= 1'b0;
        instr_op_o <= CFD_OP_NONE;
        instr_word_o <= ~word;
    endtask
endmodule

`default_nettype wire

// file: verif/cfd_compute_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of decode results and status updates
module cfd_compute_monitor
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic instr_valid_i,
    input wire cfd_pkg::cfd_op_t instr_op_i,
    input wire logic [31:0] instr_word_i,
    input wire logic sticky_clr_i,
    input wire logic dec_valid_o,
    input wire logic illegal_o,
    input wire logic [3:0] mul_result_pair_sel_o,
    input wire logic [3:0] addsub_result_pair_sel_o,
    input wire logic [3:0] mul_src1_pair_sel_o,
    input wire logic [3:0] mul_src2_pair_sel_o,
    input wire logic [3:0] addsub_src1_pair_sel_o,
    input wire logic [3:0] addsub_src2_pair_sel_o,
    input wire logic mul_result_transfer_op_o,
    input wire logic mul_result_move_dir_o,
    input wire logic [3:0] dest_data_reg_o,
    input wire logic float_op_flag_o,
    input wire logic alu_overflow_flag_o,
    input wire logic alu_invalid_flag_o,
    input wire logic alu_sign_flag_o,
    input wire logic [7:0] compare_history_bits_o,
    input wire logic alu_overflow_sticky_o,
    input wire logic alu_underflow_sticky_o,
    input wire logic alu_invalid_sticky_o,
    input wire logic alu_float_overflow_sticky_o
);
    import cfd_pkg::*;

    default clocking dc @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);

    // Qualified requests; any odd selector bit makes a 64-bit word illegal
    wire [31:0] w = instr_word_i;
    wire mf_go = instr_valid_i && instr_op_i == CFD_OP_MF64;
    wire mf_odd = |{w[12], w[8], w[6], w[4], w[2], w[0]};
    wire mv_go = instr_valid_i && instr_op_i == CFD_OP_MRMOVE;
    wire sl_ok = !w[15] && w[13:12] != 2'b11;
    wire fx_go = instr_valid_i && instr_op_i == CFD_OP_FXADD;
    wire [3:0] w_hi = w[15:12];
    wire [3:0] w_mid = w[11:8];
    wire w_dir = w[16];
    wire [7:0] e_mul = {2'b00, w[7], 1'b0, 2'b01, w[5], 1'b0};
    wire [7:0] e_add = {2'b10, w[3], 1'b0, 2'b11, w[1], 1'b0};
    wire [2:0] other_sticky = {alu_underflow_sticky_o,
        alu_invalid_sticky_o, alu_float_overflow_sticky_o};

    a_mul_res_sel: assert property (
        mf_go && !mf_odd |=> dec_valid_o && mul_result_pair_sel_o == $past(w_hi))
        else $error("multiplier result pair wrong");
    a_add_res_sel: assert property (
        mf_go && !mf_odd |=> addsub_result_pair_sel_o == $past(w_mid))
        else $error("add result pair wrong");
    a_mul_src_sel: assert property (
        mf_go && !mf_odd |=>
        {mul_src1_pair_sel_o, mul_src2_pair_sel_o} == $past(e_mul))
        else $error("multiplier source pair wrong");
    a_add_src_sel: assert property (
        mf_go && !mf_odd |=>
        {addsub_src1_pair_sel_o, addsub_src2_pair_sel_o} == $past(e_add))
        else $error("add source pair wrong");
    a_mf_refused: assert property (
        mf_go && mf_odd |=> illegal_o && !dec_valid_o
        && $stable(mul_result_pair_sel_o))
        else $error("odd selector not refused");
    a_move_decode: assert property (
        mv_go && sl_ok |=> mul_result_transfer_op_o
        && mul_result_move_dir_o == $past(w_dir) && dest_data_reg_o == $past(w_mid))
        else $error("move decode wrong");
    a_move_refused: assert property (
        mv_go && !sl_ok |=> illegal_o && !mul_result_transfer_op_o)
        else $error("bad slice code not refused");
    a_fixed_clears: assert property (
        fx_go |=> !float_op_flag_o && !alu_invalid_flag_o && !alu_sign_flag_o)
        else $error("fixed add left a flag set");
    a_hist_held: assert property (
        fx_go |=> $stable(compare_history_bits_o))
        else $error("compare history changed by add");
    a_ovf_sticky: assert property (
        fx_go ##1 alu_overflow_flag_o |-> alu_overflow_sticky_o)
        else $error("overflow sticky not set");
    a_sticky_held: assert property (
        fx_go && !sticky_clr_i |=> $stable(other_sticky)
        && ($past(alu_overflow_sticky_o) <= alu_overflow_sticky_o))
        else $error("sticky bits disturbed by add");

    c_mf_legal: cover property (mf_go && !mf_odd);
    c_move: cover property (mv_go && sl_ok);
    c_refused: cover property (illegal_o);
    c_sticky: cover property (alu_overflow_sticky_o);
endmodule

bind cfd_compute_decode cfd_compute_monitor u_cfd_compute_monitor (.*);

`default_nettype wire

// file: verif/test_cfd_compute_decode.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) \
    begin \
        num_checks++; \
        if ((got) !== (ex)) \
        begin \
            failures++; \
            $display("FAIL %s exp %h got %h", nm, ex, got); \
        end \
    end

module test_cfd_compute_decode;
    import cfd_pkg::*;

    // Bench-driven inputs, all defined at time zero
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic sat = 1'b0;
    logic sticky_clr = 1'b0;
    logic rf_wr_en = 1'b0;
    logic [3:0] rf_wr_idx = 4'h0;
    logic [39:0] rf_wr_data = 40'h0000000000;
    logic [3:0] rf_rd_idx = 4'h0;
    logic [2:0] slice_rd_idx = 3'h0;
    logic instr_valid;
    cfd_op_t instr_op;
    logic [31:0] instr_word, slice_q;
    logic [39:0] rf_q;
    logic dec_valid, illegal, mv_op, mv_dir, fop, fc, fn, fv, fz, fi, fs;
    logic [3:0] mres, ares, ms1, ms2, as1, as2, dreg;
    logic [7:0] hist;
    logic st_o, st_u, st_i, st_f;
    int failures = 0;
    int num_checks = 0;

    cfd_seq_model u_cfd_seq_model (.sys_clk_i(sys_clk_i),
        .instr_valid_o(instr_valid), .instr_op_o(instr_op),
        .instr_word_o(instr_word));

    cfd_compute_decode u_cfd_compute_decode (.sys_clk_i(sys_clk_i),
        .srst_i(srst_i), .instr_valid_i(instr_valid), .instr_op_i(instr_op),
        .instr_word_i(instr_word), .alu_saturate_enable_i(sat),
        .sticky_clr_i(sticky_clr), .rf_wr_en_i(rf_wr_en),
        .rf_wr_idx_i(rf_wr_idx), .rf_wr_data_i(rf_wr_data),
        .rf_rd_idx_i(rf_rd_idx), .rf_rd_data_o(rf_q),
        .slice_rd_idx_i(slice_rd_idx), .slice_rd_data_o(slice_q),
        .dec_valid_o(dec_valid), .illegal_o(illegal),
        .mul_result_pair_sel_o(mres), .addsub_result_pair_sel_o(ares),
        .mul_src1_pair_sel_o(ms1), .mul_src2_pair_sel_o(ms2),
        .addsub_src1_pair_sel_o(as1), .addsub_src2_pair_sel_o(as2),
        .mul_result_transfer_op_o(mv_op), .mul_result_move_dir_o(mv_dir),
        .dest_data_reg_o(dreg), .float_op_flag_o(fop),
        .alu_carry_flag_o(fc), .alu_negative_flag_o(fn),
        .alu_overflow_flag_o(fv), .alu_zero_flag_o(fz),
        .alu_invalid_flag_o(fi), .alu_sign_flag_o(fs),
        .compare_history_bits_o(hist), .alu_overflow_sticky_o(st_o),
        .alu_underflow_sticky_o(st_u), .alu_invalid_sticky_o(st_i),
        .alu_float_overflow_sticky_o(st_f));

    // 20 MHz clock
    initial
    begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    task automatic give_verdict();
        if (failures == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr_reg(input logic [3:0] idx, input logic [39:0] val);
        @(posedge sys_clk_i);
        rf_wr_en <= 1'b1;
        rf_wr_idx <= idx;
        rf_wr_data <= val;
        @(posedge sys_clk_i);
        rf_wr_en <= 1'b0;
    endtask

    // Both reads are registered: data is settled one edge later
    task automatic rd(input logic [3:0] r, input logic [2:0] s);
        @(posedge sys_clk_i);
        rf_rd_idx <= r;
        slice_rd_idx <= s;
        @(posedge sys_clk_i);
        #1;
    endtask

    task automatic go(input cfd_op_t op, input logic [31:0] w);
        u_cfd_seq_model.issue(op, w);
        #1;
    endtask

    // Every source code pairing and all even result pairs
    task automatic test_mf();
        logic [31:0] w;
        for (int i = 0; i < 16; i++)
        begin
            w = {16'h0000, i[2:0], 1'b0, ~i[2:0], 1'b0,
                i[3], 1'b0, i[2], 1'b0, i[1], 1'b0, i[0], 1'b0};
            go(CFD_OP_MF64, w);
            `CHK("dec_valid", 1'b1, dec_valid)
            `CHK("mul_res", w[15:12], mres)
            `CHK("add_res", w[11:8], ares)
            `CHK("mul_s1", i[3] ? 4'h2 : 4'h0, ms1)
            `CHK("mul_s2", i[2] ? 4'h6 : 4'h4, ms2)
            `CHK("add_s1", i[1] ? 4'hA : 4'h8, as1)
            `CHK("add_s2", i[0] ? 4'hE : 4'hC, as2)
        end
    endtask

    // Odd selector bits are refused and leave selectors as they were
    task automatic test_mf_bad();
        int bits [6] = '{0, 2, 4, 6, 8, 12};
        for (int b = 0; b < 6; b++)
        begin
            go(CFD_OP_MF64, 32'h00004AAA | (32'h1 << bits[b]));
            `CHK("illegal", 1'b1, illegal)
            `CHK("dec_valid", 1'b0, dec_valid)
            `CHK("mul_res held", 4'hE, mres)
            `CHK("mul_s1 held", 4'h2, ms1)
        end
    endtask

    // Round trip through every slice, then an unused slice code
    task automatic test_move();
        logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
        logic [31:0] v;
        for (int k = 0; k < 6; k++)
        begin
            v = 32'hC0DE0000 + k;
            wr_reg(4'(k + 1), {v, 8'h5A});
            go(CFD_OP_MRMOVE, {15'h0, 1'b1, codes[k], 4'(k + 1), 8'h00});
            `CHK("move op", 1'b1, mv_op)
            `CHK("move dir", 1'b1, mv_dir)
            `CHK("move reg", 4'(k + 1), dreg)
            go(CFD_OP_MRMOVE, {15'h0, 1'b0, codes[k], 4'(k + 9), 8'h00});
            `CHK("move dir", 1'b0, mv_dir)
            rd(4'(k + 9), 3'(k));
            `CHK("slice", v, slice_q)
            `CHK("reg back", {v, 8'h00}, rf_q)
        end
        go(CFD_OP_MRMOVE, {15'h0, 1'b1, 4'h3, 4'h1, 8'h00});
        `CHK("bad slice", 2'b10, {illegal, mv_op})
    endtask

    // Add table: plain, carry to zero, overflow with and without clamp
    task automatic test_add();
        logic [31:0] ta [6] = '{32'h1, 32'hFFFFFFFF, 32'h7FFFFFFF,
            32'h7FFFFFFF, 32'h80000000, 32'h80000000};
        logic [31:0] tb [6] = '{32'h2, 32'h1, 32'h1, 32'h1,
            32'h80000000, 32'h80000000};
        logic ts [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        logic [31:0] tr [6] = '{32'h3, 32'h0, 32'h80000000,
            32'h7FFFFFFF, 32'h80000000, 32'h0};
        logic [3:0] tf [6] = '{4'h0, 4'h9, 4'h6, 4'h2, 4'hE, 4'hB};
        logic exp_st;
        exp_st = 1'b0;
        for (int k = 0; k < 6; k++)
        begin
            wr_reg(4'h2, {ta[k], 8'hFF});
            wr_reg(4'h3, {tb[k], 8'h11});
            sat <= ts[k];
            go(CFD_OP_FXADD, {20'h00000, 4'(k + 4), 8'h23});
            exp_st = exp_st | tf[k][1];
            `CHK("c n v z", tf[k], {fc, fn, fv, fz})
            `CHK("float op", 1'b0, fop)
            `CHK("inv sign", 2'b00, {fi, fs})
            `CHK("history", 8'h00, hist)
            `CHK("ovf sticky", exp_st, st_o)
            `CHK("other sticky", 3'h0, {st_u, st_i, st_f})
            rd(4'(k + 4), 3'h0);
            `CHK("sum", {tr[k], 8'h00}, rf_q)
        end
        @(posedge sys_clk_i);
        sticky_clr <= 1'b1;
        @(posedge sys_clk_i);
        sticky_clr <= 1'b0;
        #1;
        `CHK("sticky clear", 1'b0, st_o)
    endtask

    // Main sequence
    initial
    begin
        repeat (20) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        test_mf();
        test_mf_bad();
        test_move();
        test_add();
        give_verdict();
    end

    // Whole run needs under two hundred cycles
    initial
    begin
        repeat (5000) @(posedge sys_clk_i);
        failures++;
        give_verdict();
    end
endmodule

`default_nettype wire
